// file: pkg/sar_adc_pkg.sv
// Shared constants for the parallel-readout converter control logic.
// Assumes a single 250 MHz system clock; all pin inputs synchronous to it.
package sar_adc_pkg;

    localparam int          DATA_W          = 16;
    localparam int          BYTE_W          = 8;
    localparam int          MCLK_PERIOD_NS  = 4;
    localparam int          START_MIN_NS    = 20;
    // Least time, so round up
    localparam int          START_MIN_CYC   =
        (START_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int          QUAL_CNT_W      = 3;
    localparam logic [15:0] RESULT_RST      = 16'h0000;
    localparam logic [15:0] DAC_RST         = 16'h0000;

    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'h0,
        ST_QUALIFY = 2'h1,
        ST_CONVERT = 2'h3,
        ST_CAPTURE = 2'h2
    } conv_state_e;

endpackage

// file: hdl/sar_step_engine.sv
// Successive-approximation bit engine: one bit decided per step pulse.
// Assumes begin and step are single-cycle pulses from the control block.
`timescale 1ns/1ps

module sar_step_engine
    import sar_adc_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             beginConv,
    input  wire logic             stepConv,
    input  wire logic             compHigh,
    output logic [WIDTH-1:0]      dacCode,
    output logic                  engineDone
);

    localparam int IDX_W = $clog2(WIDTH);

    logic [IDX_W-1:0] bitIdx_reg;
    logic             active_reg;

    // Trial code drives the capacitor DAC; compHigh answers each trial
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dacCode    <= DAC_RST[WIDTH-1:0];
            bitIdx_reg <= IDX_W'(WIDTH - 1);
            active_reg <= 1'b0;
        end
        else if (beginConv)
        begin
            dacCode    <= {1'b1, {(WIDTH-1){1'b0}}};
            bitIdx_reg <= IDX_W'(WIDTH - 1);
            active_reg <= 1'b1;
        end
        else if (stepConv && active_reg)
        begin
            if (!compHigh)
                dacCode[bitIdx_reg] <= 1'b0;
            if (bitIdx_reg != '0)
                dacCode[bitIdx_reg - 1'b1] <= 1'b1;
            else
                active_reg <= 1'b0;
            bitIdx_reg <= bitIdx_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            engineDone <= 1'b0;
        else
            engineDone <= stepConv && active_reg && (bitIdx_reg == '0);
    end

endmodule

// file: hdl/sar_adc_parallel_readout.sv
// Digital control of a 16-bit SAR converter with a parallel result bus.
// Assumes host pins are synchronous to mclk; the conversion clock from the
// host is sampled as an ordinary input and its rising edges step the SAR.
`timescale 1ns/1ps

module sar_adc_parallel_readout
    import sar_adc_pkg::*;
#(
    parameter int START_CYC = START_MIN_CYC
)
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              convClk,
    input  wire logic              conversion_start_n,
    input  wire logic              chipSelect_n,
    input  wire logic              readStrobe_n,
    input  wire logic              byteSel,
    input  wire logic              compHigh,
    output logic [DATA_W-1:0]      result_bus,
    output logic                   resultBusEn_n,
    output logic                   busy,
    output logic                   holdSample,
    output logic [DATA_W-1:0]      dacCode
);

    localparam int RISE_W = $clog2(DATA_W) + 1;

    conv_state_e            state_reg;
    conv_state_e            state_next;
    logic [QUAL_CNT_W-1:0]  qualCnt_reg;
    logic                   startArmed_reg;
    logic                   convClkPrev_reg;
    logic [DATA_W-1:0]      result_reg;
    logic                   convRise;
    logic                   qualDone;
    logic                   engineDone;
    logic                   readActive;
    logic                   inCapture;
    logic [RISE_W-1:0]      riseCnt_reg;

    function automatic logic [DATA_W-1:0] busWord
    (
        input logic [DATA_W-1:0] word,
        input logic              sel
    );
        busWord = {word[DATA_W-1:BYTE_W],
                   sel ? word[BYTE_W-1:0] : word[DATA_W-1:BYTE_W]};
    endfunction

    assign convRise   = convClk && !convClkPrev_reg;
    assign qualDone   = (state_reg == ST_QUALIFY) && !conversion_start_n
                        && (qualCnt_reg == QUAL_CNT_W'(START_CYC - 1));
    assign readActive = !chipSelect_n && !readStrobe_n;
    assign inCapture  = (state_reg == ST_CAPTURE);

    always_ff @(posedge mclk)
    begin
        if (rst)
            convClkPrev_reg <= 1'b0;
        else
            convClkPrev_reg <= convClk;
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (!conversion_start_n && startArmed_reg)
                    state_next = ST_QUALIFY;
            ST_QUALIFY:
                if (conversion_start_n)
                    state_next = ST_IDLE;
                else if (qualDone)
                    state_next = ST_CONVERT;
            ST_CONVERT:
                if (engineDone)
                    state_next = ST_CAPTURE;
            ST_CAPTURE:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge mclk)
    begin
        if (rst || state_reg != ST_QUALIFY)
            qualCnt_reg <= QUAL_CNT_W'(1);
        else
            qualCnt_reg <= qualCnt_reg + 1'b1;
    end

    // A start held low through a whole conversion must not retrigger
    always_ff @(posedge mclk)
    begin
        if (rst)
            startArmed_reg <= 1'b1;
        else if (conversion_start_n)
            startArmed_reg <= 1'b1;
        else if (state_reg == ST_IDLE)
            startArmed_reg <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busy       <= 1'b0;
            holdSample <= 1'b0;
        end
        else if (qualDone)
        begin
            busy       <= 1'b1;
            holdSample <= 1'b1;
        end
        else if (inCapture)
        begin
            busy       <= 1'b0;
            holdSample <= 1'b0;
        end
    end

    // Engine is offset binary; flipping the MSB gives two's complement
    always_ff @(posedge mclk)
    begin
        if (rst)
            result_reg <= RESULT_RST;
        else if (state_reg == ST_CONVERT && engineDone)
            result_reg <= {~dacCode[DATA_W-1], dacCode[DATA_W-2:0]};
    end

    // One cycle of latency; bus is released whenever the strobe is gone
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            result_bus    <= RESULT_RST;
            resultBusEn_n <= 1'b1;
        end
        else
        begin
            resultBusEn_n <= !readActive;
            if (readActive)
                result_bus <= busWord(result_reg, byteSel);
        end
    end

    sar_step_engine #(
        .WIDTH      (DATA_W)
    ) u_engine (
        .mclk       (mclk),
        .rst        (rst),
        .beginConv  (qualDone),
        .stepConv   (convRise && state_reg == ST_CONVERT),
        .compHigh   (compHigh),
        .dacCode    (dacCode),
        .engineDone (engineDone)
    );

    // Checking aid only: conversion clock rises seen in this conversion
    always_ff @(posedge mclk)
    begin
        if (rst || state_reg != ST_CONVERT)
            riseCnt_reg <= '0;
        else if (convRise)
            riseCnt_reg <= riseCnt_reg + 1'b1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_BUSY_SPAN: assert property (
        busy == (state_reg == ST_CONVERT || state_reg == ST_CAPTURE))
        else $error("busy does not match conversion span");

    AST_STEP_ON_CONV_CLK: assert property (
        (state_reg == ST_CONVERT) && $past(state_reg == ST_CONVERT)
        && $changed(dacCode) |-> $past(convRise))
        else $error("SAR stepped without conversion clock edge");

    AST_BYTE_SELECT: assert property (
        readActive && !byteSel
        |=> result_bus[BYTE_W-1:0] == $past(result_reg[DATA_W-1:BYTE_W]))
        else $error("byte select low did not give upper byte");

    AST_LOWER_BYTE: assert property (
        readActive && byteSel |=> result_bus == $past(result_reg))
        else $error("byte select high did not give lower byte");

    AST_READ_DRIVE: assert property (
        readActive |=> !resultBusEn_n ##1 (resultBusEn_n == $past(!readActive)))
        else $error("result bus enable not following read strobe");

    AST_TWOS_COMP: assert property (
        (state_reg == ST_CONVERT) && engineDone
        |=> result_reg == {~$past(dacCode[DATA_W-1]),
                           $past(dacCode[DATA_W-2:0])})
        else $error("result not in two's complement form");

    AST_START_MIN_LOW: assert property (
        $rose(holdSample) |-> $past(!conversion_start_n, 1)
        && $past(!conversion_start_n, START_CYC) && busy)
        else $error("hold entered without qualified start");

    // A start left low across the end of a conversion stays unarmed
    AST_NO_RETRIGGER: assert property (
        $fell(busy) && !conversion_start_n |=> state_reg == ST_IDLE)
        else $error("held start retriggered a conversion");

    AST_RISE_COUNT: assert property (
        (state_reg == ST_CONVERT) && engineDone
        |-> riseCnt_reg == RISE_W'(DATA_W))
        else $error("conversion did not take one bit per clock rise");

    AST_BUSY_AFTER_LOAD: assert property (
        $fell(busy) |-> $past(inCapture) && $stable(result_reg))
        else $error("busy fell before result was captured");

    AST_RESULT_WHILE_BUSY: assert property (
        $changed(result_reg) |-> busy)
        else $error("result register changed outside a conversion");

endmodule

// file: testbench/host_side_model.sv
// Host side: free conversion clock and comparator answer.
// Assumes dacCode is offset binary and target is the input code.
`timescale 1ns/1ps

module host_side_model
(
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic [15:0] target,
    input  wire logic [15:0] dacCode,
    output logic             convClk,
    output logic             compHigh
);
    int cnt = 0;

    initial convClk = 1'b0;

    // 104 or 208 ns period, inside the legal range
    always @(posedge mclk)
    begin
        cnt <= cnt + 1;
        if (cnt >= (slow ? 25 : 12))
        begin
            cnt     <= 0;
            convClk <= ~convClk;
        end
    end

    // Keep the bit while the trial stays at or below the input
    assign compHigh = (dacCode <= target);
endmodule

// file: testbench/test_sar_adc_parallel_readout.sv
// Self-checking bench for the parallel-readout converter control.
// Assumes host_side_model supplies convClk and the comparator.
`timescale 1ns/1ps

module test_sar_adc_parallel_readout
    import sar_adc_pkg::*;
;
    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    logic              convClk;
    logic              conversion_start_n = 1'b1;
    logic              chipSelect_n = 1'b1;
    logic              readStrobe_n = 1'b1;
    logic              byteSel = 1'b0;
    logic              compHigh;
    logic              slow = 1'b0;
    logic [15:0]       target = 16'h0000;
    logic [DATA_W-1:0] result_bus;
    logic [DATA_W-1:0] dacCode;
    logic              resultBusEn_n;
    logic              busy;
    logic              holdSample;
    logic [15:0]       lastRes = 16'h0000;
    logic [15:0]       expQ[$];
    int                failures = 0;
    int                cmp_count = 0;

    always #2 mclk = ~mclk;

    sar_adc_parallel_readout dut (.mclk(mclk), .rst(rst), .convClk(convClk),
        .conversion_start_n(conversion_start_n), .chipSelect_n(chipSelect_n),
        .readStrobe_n(readStrobe_n), .byteSel(byteSel), .compHigh(compHigh),
        .result_bus(result_bus), .resultBusEn_n(resultBusEn_n), .busy(busy),
        .holdSample(holdSample), .dacCode(dacCode));

    host_side_model partner (.mclk(mclk), .slow(slow), .target(target),
        .dacCode(dacCode), .convClk(convClk), .compHigh(compHigh));

    task automatic summarize();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Bounded wait; a hang ends the run
    task automatic waitBusy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 3000)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 3000)
        begin
            failures++;
            $display("[ERR] %0t busy wait timeout", $time);
            summarize();
        end
    endtask

    // Upper byte first, byte switched with the strobe held low
    task automatic read(input logic [15:0] r);
        chipSelect_n = 1'b0;
        readStrobe_n = 1'b0;
        byteSel = 1'b0;
        expQ.push_back({r[15:8], r[15:8]});
        @(posedge mclk);
        #1;
        byteSel = 1'b1;
        expQ.push_back(r);
        @(posedge mclk);
        #1;
        chipSelect_n = 1'b1;
        readStrobe_n = 1'b1;
        @(posedge mclk);
        #1;
        check({15'h0000, resultBusEn_n}, 16'h0001);
    endtask

    task automatic convert(input logic [15:0] t, input logic s);
        target = t;
        slow = s;
        conversion_start_n = 1'b0;
        waitBusy(1'b1);
        check(dacCode, 16'h8000);
        check({15'h0000, holdSample}, 16'h0001);
        conversion_start_n = 1'b1;
        // Mid-conversion read still shows the old word
        read(lastRes);
        waitBusy(1'b0);
        check({15'h0000, holdSample}, 16'h0000);
        lastRes = t ^ 16'h8000;
        read(lastRes);
    endtask

    always @(negedge mclk)
    begin
        if (resultBusEn_n === 1'b0)
        begin
            if (expQ.size() == 0)
            begin
                failures++;
                $display("[ERR] %0t unexpected bus drive", $time);
            end
            else
                check(result_bus, expQ.pop_front());
        end
    end

    initial
    begin
        logic [15:0] vals[4];
        vals = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
        void'($urandom(32'h62AF));
        repeat (6) @(posedge mclk);
        #1;
        rst = 1'b0;
        check({busy, holdSample, resultBusEn_n}, 16'h0001);
        check(dacCode, 16'h0000);
        // Too short a start must not convert
        conversion_start_n = 1'b0;
        repeat (START_MIN_CYC - 1) @(posedge mclk);
        #1;
        conversion_start_n = 1'b1;
        repeat (10) @(posedge mclk);
        #1;
        check({15'h0000, busy}, 16'h0000);
        $display("short start done");
        for (int i = 0; i < 4; i++)
            convert(vals[i], i[0]);
        $display("boundary codes done");
        repeat (6)
            convert(16'($urandom()), 1'($urandom()));
        $display("random codes done");
        // Start held low across the end of a conversion must not retrigger
        target = 16'($urandom());
        conversion_start_n = 1'b0;
        waitBusy(1'b1);
        waitBusy(1'b0);
        repeat (10) @(posedge mclk);
        #1;
        check({15'h0000, busy}, 16'h0000);
        conversion_start_n = 1'b1;
        lastRes = target ^ 16'h8000;
        read(lastRes);
        $display("held start done");
        check(16'(expQ.size()), 16'h0000);
        summarize();
    end
endmodule
